// *** rtl/mtp_prog.sv ***
/*
 Programming-mode interface of the on-chip MTP program ROM with its
 security register, plus the table-read access filter used in normal mode.
 Assumes: pins are asynchronous and held steady for microseconds per
 operation; the table-read request comes from logic on clk_sys_i.
*/
// Operation
// RULE1: Programming mode needs reset high, latch strobe low, program store strobe high.
// RULE2: Program level, chip enable low, output enable high writes the byte.
// RULE3: Programmer reads each byte back with chip enable high, output enable low.
// RULE4: Only erase turns bits to 1; it sets every cell and security bit. The code also sets both at reset: cells by the walk, security bits directly.
// RULE5: Erase needs erase level, mode select A high, A0 low, data 0FFH.
// RULE6: Erase verify drives each addressed byte while erase level is held.
// RULE7: Chip enable and output enable both high inhibit program and erase.
// RULE8: Identifier read gives company code for A0 low, device code for high.
// RULE9: Security and identifier registers are reachable only in programming mode.
// RULE10: A programmed security bit stays 0 until whole-chip erase. The code also sets it back to 1 at reset.
// RULE11: Security register sits at address FFFF in programming mode.
// RULE12: Identifier values are fixed; no operation alters them.
// RULE13: Lock bit 0 blocks all access to ROM and setting registers.
// RULE14: Restriction bit 0 keeps external-code table reads away from internal ROM.
// RULE15: Internal-code table reads reach internal memory regardless of restriction.
// RULE16: Restriction bit 1 places no limit on table reads.
// RULE17: Enabled encryption encodes data on the data port; only erase clears it. The code also clears it at reset.
// RULE18: Read returns code and security bits; invalid once lock is programmed.
// RULE19: Output enable high leaves the data lines undriven.
// RULE20: Mode selects B, C, D must be low; otherwise nothing happens.
// RULE21: Lock, restriction, encryption bits at chosen positions, all 1 after erase.
`timescale 1ns/10ps
module mtp_prog
   import mtp_pkg::*;
#(
   parameter int ROM_DEPTH = 4096,
   parameter logic [DATA_W-1:0] COMPANY_ID = 8'hA5, // Arbitrary value
   parameter logic [DATA_W-1:0] DEVICE_ID = 8'h3C, // Arbitrary value
   parameter logic [DATA_W-1:0] ENC_KEY = 8'h96 // Arbitrary value
) (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire mtp_pins_s pins_i,
   input wire mtp_trd_req_s trd_req_i,
   output logic [DATA_W-1:0] data_o,
   output logic data_oe_n_o,
   output logic trd_internal_o,
   output logic [DATA_W-1:0] trd_data_o,
   output logic erase_busy_o
);
   localparam int AW = $clog2(ROM_DEPTH);
   localparam logic [ADDR_W:0] ROM_LIMIT = (ADDR_W+1)'(ROM_DEPTH);
   localparam logic [AW-1:0] LAST_CELL = AW'(ROM_DEPTH - 1);

   typedef struct packed {
      mtp_state_e st;
      logic [AW-1:0] cnt;
      logic ce_d;
      logic [DATA_W-1:0] sec;
      logic [DATA_W-1:0] data;
      logic data_oe_n;
      logic trd_int;
      logic [DATA_W-1:0] trd_data;
   } mtp_core_s;

   // ----------------------------------------------------------------
   // Reset release and pin synchronisers
   // ----------------------------------------------------------------
   logic rst_meta_ff;
   logic rst_n_ff;
   mtp_pins_s pins_q;

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff <= rst_meta_ff;
      end
   end

   mtp_sync #(
      .W($bits(mtp_pins_s))
   ) u_pin_sync (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_ff),
      .d_i(pins_i),
      .q_o(pins_q)
   );

   // ----------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------
   function automatic logic prog_mode(input mtp_pins_s p);
      prog_mode = p.rst & !p.ale & p.program_store_strobe_n;
   endfunction

   function automatic mtp_op_e decode_op(input mtp_pins_s p);
      mtp_op_e r;
      r = OP_NONE;
      if (p.mode_select_b | p.mode_select_c | p.mode_select_d) begin
         r = OP_NONE; // RULE20
      end else if (!p.mode_select_a) begin
         if (!p.ce_n && !p.oe_n && p.vpp == VPP_HIGH) begin
            r = OP_READ; // RULE18
         end else if (!p.ce_n && p.oe_n && p.vpp == VPP_PROG) begin
            r = OP_PROG; // RULE2
         end else if (p.ce_n && !p.oe_n && p.vpp == VPP_PROG) begin
            r = OP_VERIFY; // RULE3
         end
      end else begin
         if (!p.ce_n && p.oe_n && p.vpp == VPP_ERASE) begin
            r = OP_ERASE; // RULE5
         end else if (p.ce_n && !p.oe_n && p.vpp == VPP_ERASE) begin
            r = OP_VERIFY; // RULE6
         end else if (!p.ce_n && !p.oe_n && p.vpp == VPP_HIGH) begin
            r = OP_ID; // RULE8
         end
      end
      // Both enables high never decodes to a writing operation
      if (p.ce_n && p.oe_n) begin
         r = OP_NONE; // RULE7
      end
      decode_op = r;
   endfunction

   function automatic logic [DATA_W-1:0] encode(input logic [DATA_W-1:0] d, input logic [ADDR_W-1:0] a);
      encode = d ^ ENC_KEY ^ a[DATA_W-1:0];
   endfunction

   // ----------------------------------------------------------------
   // ROM array
   // ----------------------------------------------------------------
   // No reset on the array; the walk after reset leaves it blank
   logic [DATA_W-1:0] rom [ROM_DEPTH];
   logic mem_we;
   logic [AW-1:0] mem_wa;
   logic [DATA_W-1:0] mem_wd;

   always_ff @(posedge clk_sys_i) begin
      if (mem_we) begin
         rom[mem_wa] <= mem_wd;
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   mtp_core_s cur;
   mtp_core_s nxt_cur;
   mtp_op_e op;
   logic pm;
   logic ce_fall;
   logic locked;
   logic in_rom;
   logic trd_in_rom;
   logic trd_ok;
   logic erase_go;
   logic drive;
   logic [DATA_W-1:0] rom_rd;
   logic [DATA_W-1:0] trd_rd;

   always_comb begin
      nxt_cur = cur;
      mem_we = 1'b0;
      mem_wa = cur.cnt;
      mem_wd = BLANK_BYTE;
      pm = prog_mode(pins_q); // RULE1
      op = pm ? decode_op(pins_q) : OP_NONE; // RULE1
      ce_fall = cur.ce_d & !pins_q.ce_n;
      nxt_cur.ce_d = pins_q.ce_n;
      locked = !cur.sec[SEC_LOCK_BIT];
      in_rom = {1'b0, pins_q.addr} < ROM_LIMIT;
      rom_rd = rom[pins_q.addr[AW-1:0]];
      erase_go = (cur.st == ST_IDLE) && (op == OP_ERASE) && ce_fall && !pins_q.addr[0]
                 && (pins_q.data == ERASE_PATTERN); // RULE5
      unique case (cur.st)
         ST_IDLE: begin
            if (erase_go) begin
               nxt_cur.sec = SEC_RESET; // RULE4 RULE21
               nxt_cur.cnt = '0;
               nxt_cur.st = ST_ERASE;
            end else if (op == OP_PROG && ce_fall && !locked) begin // RULE13
               if (pins_q.addr == SEC_ADDR) begin
                  // Programming only clears bits, so a 0 never returns here
                  nxt_cur.sec = cur.sec & pins_q.data; // RULE10 RULE11 RULE17
               end else if (in_rom) begin
                  mem_we = 1'b1; // RULE2
                  mem_wa = pins_q.addr[AW-1:0];
                  mem_wd = rom_rd & pins_q.data; // RULE4
               end
            end
         end
         ST_ERASE: begin
            // One cell per cycle; verify reads wait until the walk ends
            mem_we = 1'b1; // RULE4
            mem_wa = cur.cnt;
            mem_wd = BLANK_BYTE;
            if (cur.cnt == LAST_CELL) begin
               nxt_cur.st = ST_IDLE;
            end else begin
               nxt_cur.cnt = cur.cnt + 1'b1;
            end
         end
      endcase

      // Data port drive
      drive = (cur.st == ST_IDLE) && !pins_q.oe_n
              && (op == OP_READ || op == OP_VERIFY || op == OP_ID); // RULE9 RULE19
      nxt_cur.data_oe_n = !drive; // RULE19
      nxt_cur.data = IDLE_BYTE;
      if (drive) begin
         if (locked) begin
            nxt_cur.data = LOCKED_BYTE; // RULE13 RULE18
         end else if (op == OP_ID) begin
            // Identifier values are parameters with no write path
            nxt_cur.data = pins_q.addr[0] ? DEVICE_ID : COMPANY_ID; // RULE8 RULE12
         end else if (pins_q.addr == SEC_ADDR) begin
            nxt_cur.data = cur.sec; // RULE11 RULE18
         end else if (in_rom) begin
            nxt_cur.data = cur.sec[SEC_ENC_BIT] ? rom_rd : encode(rom_rd, pins_q.addr); // RULE17
         end else begin
            nxt_cur.data = BLANK_BYTE;
         end
      end

      // Normal-mode table read filter
      trd_in_rom = {1'b0, trd_req_i.addr} < ROM_LIMIT;
      trd_rd = rom[trd_req_i.addr[AW-1:0]];
      trd_ok = trd_req_i.valid && trd_in_rom
               && (trd_req_i.from_internal || cur.sec[SEC_TRD_BIT]); // RULE14 RULE15 RULE16
      nxt_cur.trd_int = trd_ok;
      nxt_cur.trd_data = trd_ok ? trd_rd : IDLE_BYTE; // RULE14
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         // Reset starts a blanking walk so contents are always defined
         cur.st <= ST_ERASE;
         cur.cnt <= '0;
         cur.ce_d <= 1'b1;
         cur.sec <= SEC_RESET; // RULE21
         cur.data <= IDLE_BYTE;
         cur.data_oe_n <= 1'b1;
         cur.trd_int <= 1'b0;
         cur.trd_data <= IDLE_BYTE;
      end else begin
         cur <= nxt_cur;
      end
   end

   assign data_o = cur.data;
   assign data_oe_n_o = cur.data_oe_n;
   assign trd_internal_o = cur.trd_int;
   assign trd_data_o = cur.trd_data;
   // One-hot code: bit 1 alone marks the walk, so the pin is a bare flop
   assign erase_busy_o = cur.st[1];

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_oe_high_float: assert property ( // RULE19
      @(posedge clk_sys_i) disable iff (!rst_n_ff)
      pins_q.oe_n |=> data_oe_n_o)
      else $error("data port driven while output enable high");

   chk_mode_gate: assert property ( // RULE9
      @(posedge clk_sys_i) disable iff (!rst_n_ff)
      !prog_mode(pins_q) |=> data_oe_n_o && !$past(mem_we && cur.st == ST_IDLE))
      else $error("programming access outside programming mode");

   chk_inhibit_write: assert property ( // RULE7
      @(posedge clk_sys_i) disable iff (!rst_n_ff)
      (pins_q.ce_n && pins_q.oe_n && cur.st == ST_IDLE) |-> !mem_we && !erase_go)
      else $error("write while chips are inhibited");

   chk_sec_sticky: assert property ( // RULE10
      @(posedge clk_sys_i) disable iff (!rst_n_ff)
      !erase_go |=> (cur.sec & ~$past(cur.sec)) == 8'h00)
      else $error("security bit returned to 1 without erase");

   chk_erase_sets: assert property ( // RULE4
      @(posedge clk_sys_i) disable iff (!rst_n_ff)
      erase_go |=> cur.sec == SEC_RESET ##0 erase_busy_o [*8])
      else $error("erase did not set security and walk the array");

   chk_lock_read: assert property ( // RULE13
      @(posedge clk_sys_i) disable iff (!rst_n_ff)
      (locked && op == OP_READ && !pins_q.oe_n && cur.st == ST_IDLE) |=> data_o == LOCKED_BYTE)
      else $error("locked device returned content");

   chk_id_read: assert property ( // RULE8
      @(posedge clk_sys_i) disable iff (!rst_n_ff)
      (!locked && op == OP_ID && cur.st == ST_IDLE)
      |=> data_o == ($past(pins_q.addr[0]) ? DEVICE_ID : COMPANY_ID) && !data_oe_n_o)
      else $error("identifier read returned wrong code");

   chk_trd_restrict: assert property ( // RULE14
      @(posedge clk_sys_i) disable iff (!rst_n_ff)
      (trd_req_i.valid && !trd_req_i.from_internal && !cur.sec[SEC_TRD_BIT])
      |=> !trd_internal_o && trd_data_o == IDLE_BYTE)
      else $error("restricted table read reached internal ROM");

   chk_trd_internal: assert property ( // RULE15
      @(posedge clk_sys_i) disable iff (!rst_n_ff)
      (trd_req_i.valid && trd_req_i.from_internal && trd_in_rom) |=> trd_internal_o)
      else $error("internal table read was refused");

   chk_sec_read: assert property ( // RULE11
      @(posedge clk_sys_i) disable iff (!rst_n_ff)
      (!locked && op == OP_READ && pins_q.addr == SEC_ADDR && cur.st == ST_IDLE)
      |=> data_o == $past(cur.sec))
      else $error("security register not at top address");

   chk_lock_nowrite: assert property ( // RULE13
      @(posedge clk_sys_i) disable iff (!rst_n_ff)
      (locked && cur.st == ST_IDLE) |-> !mem_we)
      else $error("locked device wrote the array");

   chk_erase_refuse: assert property ( // RULE5
      @(posedge clk_sys_i) disable iff (!rst_n_ff)
      (cur.st == ST_IDLE && (pins_q.addr[0] || pins_q.data != ERASE_PATTERN)) |=> !erase_busy_o)
      else $error("erase started without address bit 0 low and blank data");

   chk_trd_open: assert property ( // RULE16
      @(posedge clk_sys_i) disable iff (!rst_n_ff)
      (trd_req_i.valid && trd_in_rom && cur.sec[SEC_TRD_BIT])
      |=> trd_internal_o && trd_data_o == $past(trd_rd))
      else $error("unrestricted table read was refused");

   chk_verify_drive: assert property ( // RULE6
      @(posedge clk_sys_i) disable iff (!rst_n_ff)
      (op == OP_VERIFY && pins_q.vpp == VPP_ERASE && cur.st == ST_IDLE) |=> !data_oe_n_o)
      else $error("erase verify left the data port floating");

   chk_walk_quiet: assert property ( // RULE6
      @(posedge clk_sys_i) disable iff (!rst_n_ff)
      erase_busy_o |=> data_oe_n_o)
      else $error("data port driven during the erase walk");
endmodule // mtp_prog

// *** rtl/mtp_pkg.sv ***
/*
 Shared constants, pin bundles and enumerations of the programming-mode
 interface to the on-chip MTP program ROM.
 Assumes: one 250 MHz system clock; all pin levels arrive already decoded
 to logic levels, with the programming voltage reported as a 2-bit level code.
*/
package mtp_pkg;

   // ----------------------------------------------------------------
   // Widths and map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] SEC_ADDR = 16'hFFFF;

   // ----------------------------------------------------------------
   // Values
   // ----------------------------------------------------------------
   localparam logic [DATA_W-1:0] ERASE_PATTERN = 8'hFF;
   localparam logic [DATA_W-1:0] SEC_RESET = 8'hFF;
   localparam logic [DATA_W-1:0] BLANK_BYTE = 8'hFF;
   localparam logic [DATA_W-1:0] LOCKED_BYTE = 8'hFF;
   localparam logic [DATA_W-1:0] IDLE_BYTE = 8'h00;

   // ----------------------------------------------------------------
   // Security register field positions
   // ----------------------------------------------------------------
   localparam int SEC_LOCK_BIT = 0;
   localparam int SEC_TRD_BIT = 1;
   localparam int SEC_ENC_BIT = 2;

   // ----------------------------------------------------------------
   // Programming voltage level codes
   // ----------------------------------------------------------------
   localparam logic [1:0] VPP_LOW = 2'h0;
   localparam logic [1:0] VPP_HIGH = 2'h1;
   localparam logic [1:0] VPP_PROG = 2'h2;
   localparam logic [1:0] VPP_ERASE = 2'h3;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [5:0] {
      OP_NONE = 6'h01,
      OP_READ = 6'h02,
      OP_PROG = 6'h04,
      OP_VERIFY = 6'h08,
      OP_ERASE = 6'h10,
      OP_ID = 6'h20
   } mtp_op_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h1,
      ST_ERASE = 2'h2
   } mtp_state_e;

   typedef struct packed {
      logic rst;
      logic ale;
      logic program_store_strobe_n;
      logic mode_select_a;
      logic mode_select_b;
      logic mode_select_c;
      logic mode_select_d;
      logic ce_n;
      logic oe_n;
      logic [1:0] vpp;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } mtp_pins_s;

   typedef struct packed {
      logic valid;
      logic from_internal;
      logic [ADDR_W-1:0] addr;
   } mtp_trd_req_s;

endpackage

// *** rtl/mtp_sync.sv ***
/*
 Two-flop synchroniser for a bundle of pin levels.
 Assumes: each bit is a slow level; bits need not stay coherent with
 each other across the crossing.
*/
`timescale 1ns/10ps
module mtp_sync #(
   parameter int W = 1
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_ff;

   // ----------------------------------------------------------------
   // Stages
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_ff <= '0;
         q_o <= '0;
      end else begin
         meta_ff <= d_i;
         q_o <= meta_ff;
      end
   end
endmodule // mtp_sync

// *** bench/mtp_programmer.sv ***
/*
 Behavioural ROM programmer that drives the programming pins of the MTP interface.
 Assumes: the bench calls its tasks at a falling edge of clk_sys_i.
*/
`timescale 1ns/10ps
module mtp_programmer
   import mtp_pkg::*;
(
   input wire logic clk_sys_i,
   output mtp_pins_s pins_o
);
   // ----------------------------------------------------------------
   // Idle levels
   // ----------------------------------------------------------------
   logic [2:0] stray;
   initial begin
      stray = 3'h0;
      pins_o = '0;
      pins_o.rst = 1'b1;
      pins_o.program_store_strobe_n = 1'b1;
      pins_o.ce_n = 1'b1;
      pins_o.oe_n = 1'b1;
      pins_o.vpp = VPP_HIGH;
   end

   // ----------------------------------------------------------------
   // Pin operations
   // ----------------------------------------------------------------
   // Mode level and a stray mode select for refusal scenarios only
   task automatic misc(input logic rst_lvl, input logic [2:0] bad);
      pins_o.rst = rst_lvl;
      stray = bad;
   endtask

   // Released data bus shows the inverse, never a stale copy
   task automatic op(input logic [1:0] v, input logic msa, input logic ce, input logic oe,
                     input logic [15:0] a, input logic [7:0] d, input logic drv);
      pins_o.vpp = v;
      pins_o.mode_select_a = msa;
      pins_o.mode_select_b = stray[0];
      pins_o.mode_select_c = stray[1];
      pins_o.mode_select_d = stray[2];
      pins_o.ce_n = ce;
      pins_o.oe_n = oe;
      pins_o.addr = a;
      pins_o.data = drv ? d : ~pins_o.data;
      repeat (6) @(negedge clk_sys_i);
   endtask

   // Chip enable pulse held well past the two sync stages
   task automatic pulse(input logic [1:0] v, input logic msa, input logic [15:0] a, input logic [7:0] d);
      op(v, msa, 1'b1, 1'b1, a, d, 1'b1);
      pins_o.ce_n = 1'b0;
      repeat (6) @(negedge clk_sys_i);
      pins_o.ce_n = 1'b1;
      repeat (6) @(negedge clk_sys_i);
   endtask
endmodule // mtp_programmer

// *** bench/test_mtp_prog.sv ***
/*
 Self-checking bench for the MTP programming interface and table-read filter.
 Assumes: mtp_programmer drives the pins; ROM depth is cut to 16 for speed.
*/
`timescale 1ns/10ps
module test_mtp_prog
   import mtp_pkg::*;
   ;
   localparam int DEPTH = 16;
   localparam logic [7:0] CID = 8'h5A; // Arbitrary value
   localparam logic [7:0] DID = 8'hC3; // Arbitrary value
   localparam logic [7:0] KEY = 8'h69; // Arbitrary value
   logic clk_sys_i, resetn_i, data_oe_n_o, trd_internal_o, erase_busy_o;
   logic [7:0] data_o, trd_data_o, sec, d;
   logic [7:0] rom [DEPTH];
   logic [15:0] ra;
   mtp_pins_s pins;
   mtp_trd_req_s trd;
   int fails, checks, seed, cyc;

   mtp_programmer PRG (.clk_sys_i(clk_sys_i), .pins_o(pins));
   mtp_prog #(.ROM_DEPTH(DEPTH), .COMPANY_ID(CID), .DEVICE_ID(DID), .ENC_KEY(KEY)) DUT (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .pins_i(pins), .trd_req_i(trd),
      .data_o(data_o), .data_oe_n_o(data_oe_n_o), .trd_internal_o(trd_internal_o),
      .trd_data_o(trd_data_o), .erase_busy_o(erase_busy_o));

   // ----------------------------------------------------------------
   // Checking helpers
   // ----------------------------------------------------------------
   task automatic conclude();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [7:0] expect_rd(input logic [15:0] a);
      if (sec[SEC_LOCK_BIT] == 1'b0) return LOCKED_BYTE;
      if (a == SEC_ADDR) return sec;
      if (a >= DEPTH) return BLANK_BYTE;
      if (sec[SEC_ENC_BIT] == 1'b0) return rom[a[3:0]] ^ KEY ^ a[7:0];
      return rom[a[3:0]];
   endfunction

   task automatic rd(input logic [1:0] v, input logic msa, input logic ce, input logic [15:0] a,
                     input logic [7:0] exp);
      PRG.op(v, msa, ce, 1'b0, a, 8'h00, 1'b0);
      cmp_bit(data_oe_n_o, 1'b0);
      cmp_byte(data_o, exp);
   endtask

   // Mirror keeps program as a bitwise clear, as the array does
   task automatic prg(input logic [15:0] a, input logic [7:0] dv);
      PRG.pulse(VPP_PROG, 1'b0, a, dv);
      if (sec[SEC_LOCK_BIT] == 1'b1 && PRG.stray == 3'h0) begin
         if (a == SEC_ADDR)
            sec &= dv;
         else if (a < DEPTH)
            rom[a[3:0]] &= dv;
      end
   endtask

   task automatic vfy(input logic [15:0] a);
      rd(VPP_PROG, 1'b0, 1'b1, a, expect_rd(a));
   endtask

   task automatic trq(input logic frm, input logic [15:0] a);
      logic ie;
      ie = (a < DEPTH) && (frm || sec[SEC_TRD_BIT]);
      trd = {1'b1, frm, a};
      @(negedge clk_sys_i);
      cmp_bit(trd_internal_o, ie);
      cmp_byte(trd_data_o, ie ? rom[a[3:0]] : 8'h00);
   endtask

   task automatic wait_idle();
      for (int i = 0; i < 200 && erase_busy_o !== 1'b0; i++)
         @(negedge clk_sys_i);
      cmp_bit(erase_busy_o, 1'b0);
      foreach (rom[i])
         rom[i] = ERASE_PATTERN;
      sec = SEC_RESET;
   endtask

   // ----------------------------------------------------------------
   // Clock and watchdog
   // ----------------------------------------------------------------
   initial begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end

   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 10000) begin
         fails++;
         conclude();
      end
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      seed = 80698;
      fails = 0;
      checks = 0;
      cyc = 0;
      resetn_i = 1'b0;
      trd = '0;
      repeat (4) @(negedge clk_sys_i);
      resetn_i = 1'b1;
      wait_idle();
      rd(VPP_HIGH, 1'b0, 1'b0, 16'h0000, BLANK_BYTE);
      rd(VPP_HIGH, 1'b0, 1'b0, SEC_ADDR, SEC_RESET);
      repeat (8) begin
         ra = 16'($random(seed)) & 16'h000F;
         d = 8'($random(seed));
         prg(ra, d);
         vfy(ra);
         prg(ra, 8'($random(seed)));
         vfy(ra);
      end
      PRG.op(VPP_HIGH, 1'b0, 1'b0, 1'b1, ra, 8'h00, 1'b0);
      cmp_bit(data_oe_n_o, 1'b1);
      PRG.op(VPP_PROG, 1'b0, 1'b1, 1'b1, 16'h0002, 8'h00, 1'b1);
      PRG.op(VPP_ERASE, 1'b1, 1'b1, 1'b1, 16'h0000, ERASE_PATTERN, 1'b1);
      cmp_bit(erase_busy_o, 1'b0);
      vfy(16'h0002);
      // Each stray mode select on its own must void the program
      for (int s = 0; s < 3; s++) begin
         PRG.misc(1'b1, 3'(1 << s));
         prg(16'h0003, 8'h00);
      end
      PRG.misc(1'b1, 3'h0);
      vfy(16'h0003);
      rd(VPP_HIGH, 1'b1, 1'b0, 16'h0000, CID);
      rd(VPP_HIGH, 1'b1, 1'b0, 16'h0001, DID);
      PRG.misc(1'b0, 3'h0);
      PRG.op(VPP_HIGH, 1'b0, 1'b0, 1'b0, SEC_ADDR, 8'h00, 1'b0);
      cmp_bit(data_oe_n_o, 1'b1);
      PRG.misc(1'b1, 3'h0);
      trq(1'b0, ra);
      trq(1'b0, 16'h0020);
      prg(SEC_ADDR, 8'hFD);
      trq(1'b0, ra);
      trq(1'b1, ra);
      trd.valid = 1'b0;
      prg(SEC_ADDR, 8'hFF);
      vfy(SEC_ADDR);
      prg(SEC_ADDR, 8'hFB);
      for (int a = 0; a < 4; a++)
         rd(VPP_HIGH, 1'b0, 1'b0, 16'(a), expect_rd(16'(a)));
      prg(SEC_ADDR, 8'hFE);
      prg(16'h0005, 8'h00);
      rd(VPP_HIGH, 1'b0, 1'b0, 16'h0005, LOCKED_BYTE);
      rd(VPP_HIGH, 1'b1, 1'b0, 16'h0000, LOCKED_BYTE);
      PRG.pulse(VPP_ERASE, 1'b1, 16'h0000, ERASE_PATTERN);
      cmp_bit(erase_busy_o, 1'b1);
      wait_idle();
      for (int a = 0; a < DEPTH; a++)
         rd(VPP_ERASE, 1'b1, 1'b1, 16'(a), BLANK_BYTE);
      rd(VPP_ERASE, 1'b1, 1'b1, SEC_ADDR, SEC_RESET);
      rd(VPP_HIGH, 1'b1, 1'b0, 16'h0001, DID);
      trq(1'b0, 16'h0001);
      trd.valid = 1'b0;
      prg(16'h0004, 8'h0F);
      // Erase with A0 high must be refused and keep the byte
      PRG.pulse(VPP_ERASE, 1'b1, 16'h0001, ERASE_PATTERN);
      cmp_bit(erase_busy_o, 1'b0);
      vfy(16'h0004);
      conclude();
   end
endmodule // test_mtp_prog
